// file: verilog/rac_device.sv
// device end: register bank reached through control byte and data word

// Summary of operation
// R1: frames are control, data high, data low
// R2: control bit seven selects register access
// R3: control bit six: clear read, set write
// R4: low six bits give register number
// R5: read requests ignore the output data word
// R6: master puts write value in data word
// R7: read answer status equals control byte
// R8: read answer returns register, high first
// R9: write answer status has bit six cleared
// R10: master discards data after write answer
// R11: locked device rejects user writes except code
// R12: unlock value in code word enables writes
// R13: other code word value relocks writes
// R14: written configuration acts only after restart
// R15: feature register is written and read back
// R16: code word clears to locked at restart
// R17: unlocked writes land in nonvolatile store
// R18: answer held; each distinct request once
module rac_device
  import rac_pkg::*;
#(
  parameter logic [15:0] FW_VERSION = 16'h3030  // arbitrary value
) (
  input  wire logic        i_clk,             // system clock
  input  wire logic        i_rst,             // synchronous reset, power cycle
  rac_link_if.dev          link,              // byte link to the master
  output logic      [15:0] o_feature_active,  // feature bits in force
  output logic             o_unlocked,        // user writes accepted
  output logic             o_access           // one request processed
);

  typedef enum logic [2:0] {
    DS_IDLE = 3'b001,
    DS_LOAD = 3'b010,
    DS_SEND = 3'b100
  } rac_dstate_t;

  // ==========================================================
  // storage
  rac_dstate_t state_q;
  rac_dstate_t state_d;
  // no power-up content in a real part; zero keeps reads defined
  logic [15:0] nv_mem [REG_COUNT] = '{default: REG_RST};  // kept across i_rst: nonvolatile
  logic [1:0]  rx_idx_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  hi_q;
  logic [7:0]  last_ctrl_q;
  logic [15:0] code_word_q;
  logic [7:0]  resp_stat_q;
  logic [15:0] resp_data_q;
  logic [23:0] tx_sh_q;
  logic [1:0]  tx_cnt_q;
  logic        boot_q;
  logic [15:0] feat_act_q;
  logic        access_q;

  // ==========================================================
  // frame reception
  wire        byte_in    = link.m_valid;
  wire        frame_done = byte_in & ~link.m_first & (rx_idx_q == RX_IDX_LO);  // R1
  wire [15:0] wr_word    = {hi_q, link.m_byte};                               // R1 R6

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_idx_q <= 2'h0;
    end else if (byte_in & (state_q == DS_IDLE)) begin
      if (link.m_first) begin
        rx_idx_q <= RX_IDX_HI;
      end else if (rx_idx_q == RX_IDX_HI) begin
        rx_idx_q <= RX_IDX_LO;
      end else begin
        rx_idx_q <= 2'h0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_q <= CTRL_IDLE;
      hi_q   <= 8'h00;
    end else if (byte_in & (state_q == DS_IDLE)) begin
      if (link.m_first) begin
        ctrl_q <= link.m_byte;  // R1
      end else if (rx_idx_q == RX_IDX_HI) begin
        hi_q <= link.m_byte;    // R1
      end
    end
  end

  // ==========================================================
  // request decode
  wire                 take      = frame_done & (state_q == DS_IDLE);
  wire                 is_reg    = ctrl_q[CTRL_REG_BIT];                  // R2
  wire                 is_wr     = ctrl_q[CTRL_WR_BIT];                   // R3
  wire [REG_NUM_W-1:0] reg_num   = ctrl_q[REG_NUM_W-1:0];                 // R4
  wire                 fresh     = ctrl_q != last_ctrl_q;                 // R18
  wire                 do_access = take & is_reg & fresh;                 // R2 R18
  wire                 do_write  = do_access & is_wr;
  wire                 hit_code  = reg_num == REG_CODE_WORD;
  wire                 hit_fw    = reg_num == REG_FW_VERSION;
  wire                 unlocked  = code_word_q == UNLOCK_CODE;             // R12 R13
  wire                 mem_we    = do_write & unlocked & ~hit_code & ~hit_fw;  // R11 R12

  // the read path never looks at the output data word
  wire [15:0] rd_word = hit_fw   ? FW_VERSION :
                        hit_code ? code_word_q :
                                   nv_mem[reg_num];  // R5 R8 R15

  // ==========================================================
  // code word, always writable
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      code_word_q <= CODE_WORD_RST;  // R16
    end else if (do_write & hit_code) begin
      code_word_q <= wr_word;        // R11 R12 R13
    end
  end

  // working and nonvolatile copies are one array surviving i_rst
  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      nv_mem[reg_num] <= wr_word;  // R15 R17
    end
  end

  // ==========================================================
  // answer formation, held until the next distinct request or plain frame
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      last_ctrl_q <= CTRL_IDLE;
      resp_stat_q <= CTRL_IDLE;
      resp_data_q <= 16'h0000;
    end else if (take & ~is_reg) begin
      // process data mode is not served here; a plain frame re-arms requests
      last_ctrl_q <= CTRL_IDLE;
      resp_stat_q <= CTRL_IDLE;
    end else if (do_access) begin
      last_ctrl_q <= ctrl_q;                                     // R18
      if (is_wr) begin
        resp_stat_q <= ctrl_q & ~CTRL_WR_MASK;                   // R9
      end else begin
        resp_stat_q <= ctrl_q;                                   // R7
        resp_data_q <= rd_word;                                  // R8
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      access_q <= 1'b0;
    end else begin
      access_q <= do_access;
    end
  end

  // ==========================================================
  // configuration in force: captured once after each restart
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      boot_q     <= 1'b1;
      feat_act_q <= REG_RST;
    end else if (boot_q) begin
      boot_q     <= 1'b0;
      feat_act_q <= nv_mem[REG_FEATURE];  // R14
    end
  end

  // ==========================================================
  // answer frame transmission
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DS_IDLE: begin
        if (take) begin
          state_d = DS_LOAD;
        end
      end
      DS_LOAD: begin
        state_d = DS_SEND;
      end
      DS_SEND: begin
        if (tx_cnt_q == 2'h1) begin
          state_d = DS_IDLE;
        end
      end
      default: begin
        state_d = DS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= DS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // every frame is answered with the held response
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_sh_q  <= 24'h000000;
      tx_cnt_q <= 2'h0;
    end else if (state_q == DS_LOAD) begin
      tx_sh_q  <= {resp_stat_q, resp_data_q};  // R1 R18
      tx_cnt_q <= TX_CNT_FULL;
    end else if (tx_cnt_q != 2'h0) begin
      tx_sh_q  <= {tx_sh_q[15:0], 8'h00};
      tx_cnt_q <= tx_cnt_q - 2'h1;
    end
  end

  assign link.s_byte      = tx_sh_q[23:16];
  assign link.s_valid     = tx_cnt_q != 2'h0;
  assign link.s_first     = tx_cnt_q == TX_CNT_FULL;
  assign o_feature_active = feat_act_q;
  assign o_unlocked       = unlocked;
  assign o_access         = access_q;

endmodule : rac_device

// file: verilog/rac_pkg.sv
// shared constants of the indirect register access link
package rac_pkg;
  // ==========================================================
  // frame layout
  localparam int unsigned FRAME_BYTES     = 3;
  localparam int unsigned CTRL_REG_BIT    = 7;
  localparam int unsigned CTRL_WR_BIT     = 6;
  localparam int unsigned REG_NUM_W       = 6;
  localparam int unsigned REG_COUNT       = 64;
  localparam logic [7:0]  CTRL_WR_MASK    = 8'h40;
  localparam logic [7:0]  CTRL_IDLE       = 8'h00;
  localparam logic [1:0]  TX_CNT_FULL     = 2'h3;
  localparam logic [1:0]  RX_IDX_HI       = 2'h1;
  localparam logic [1:0]  RX_IDX_LO       = 2'h2;

  // ==========================================================
  // register numbers and values of the device
  localparam logic [5:0]  REG_FW_VERSION  = 6'h09;
  localparam logic [5:0]  REG_CODE_WORD   = 6'h1F;
  localparam logic [5:0]  REG_FEATURE     = 6'h20;
  localparam logic [15:0] UNLOCK_CODE     = 16'h1235;
  localparam logic [15:0] CODE_WORD_RST   = 16'h0000;
  localparam logic [15:0] REG_RST         = 16'h0000;

  // ==========================================================
  // host wishbone map, byte addresses
  localparam logic [3:0]  HOST_CMD        = 4'h0;
  localparam logic [3:0]  HOST_WDATA      = 4'h4;
  localparam logic [3:0]  HOST_STATUS     = 4'h8;
  localparam logic [3:0]  HOST_RDATA      = 4'hC;
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_DONE_BIT   = 1;
  localparam int unsigned STAT_RETRY_BIT  = 2;
endpackage : rac_pkg

// file: verilog/rac_link_if.sv
// byte-serial link between the access master and the device
interface rac_link_if;
  logic [7:0] m_byte;   // master to device byte
  logic       m_valid;  // master byte present
  logic       m_first;  // master byte is byte 0
  logic [7:0] s_byte;   // device to master byte
  logic       s_valid;  // device byte present
  logic       s_first;  // device byte is byte 0

  modport dev (input m_byte, m_valid, m_first, output s_byte, s_valid, s_first);
  modport host (output m_byte, m_valid, m_first, input s_byte, s_valid, s_first);
endinterface : rac_link_if

// file: verilog/rac_host.sv
// master end: wishbone-driven issuer of register access frames
module rac_host
  import rac_pkg::*;
(
  input  wire logic        i_clk,      // system clock
  input  wire logic        i_rst,      // synchronous reset
  input  wire logic        i_wb_cyc,   // wishbone cycle
  input  wire logic        i_wb_stb,   // wishbone strobe
  input  wire logic        i_wb_we,    // wishbone write
  input  wire logic [3:0]  i_wb_adr,   // wishbone byte address
  input  wire logic [3:0]  i_wb_sel,   // wishbone byte enables
  input  wire logic [31:0] i_wb_dat,   // wishbone write data
  output logic      [31:0] o_wb_dat,   // wishbone read data
  output logic             o_wb_ack,   // wishbone acknowledge
  rac_link_if.host         link        // byte link to the device
);

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b001,
    HS_WAITC = 3'b010,
    HS_WAITR = 3'b100
  } rac_hstate_t;

  // ==========================================================
  // wishbone slave
  rac_hstate_t state_q;
  logic        ack_q;
  logic [7:0]  cmd_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic        done_q;
  logic        retry_q;
  logic [23:0] tx_sh_q;
  logic [1:0]  tx_cnt_q;
  logic [1:0]  rx_idx_q;
  logic [7:0]  stat_q;
  logic [7:0]  rhi_q;

  wire req      = i_wb_cyc & i_wb_stb & ~ack_q;
  wire wr_req   = req & i_wb_we;
  wire busy     = state_q != HS_IDLE;
  wire cmd_wr   = wr_req & (i_wb_adr == HOST_CMD) & i_wb_sel[0];
  wire start    = cmd_wr & ~busy;
  wire wd_wr    = wr_req & (i_wb_adr == HOST_WDATA);
  wire [31:0] status_word = {29'h0, retry_q, done_q, busy};
  wire [31:0] rd_mux = (i_wb_adr == HOST_CMD)    ? {24'h0, cmd_q} :
                       (i_wb_adr == HOST_WDATA)  ? {16'h0, wdata_q} :
                       (i_wb_adr == HOST_STATUS) ? status_word :
                       (i_wb_adr == HOST_RDATA)  ? {16'h0, rdata_q} : 32'h0;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_q    <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      ack_q    <= req;
      o_wb_dat <= rd_mux;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cmd_q   <= CTRL_IDLE;
      wdata_q <= 16'h0000;
    end else begin
      if (start) begin
        cmd_q <= {1'b1, i_wb_dat[6:0]};  // R2 R3 R4
      end
      if (wd_wr & i_wb_sel[0]) begin
        wdata_q[7:0] <= i_wb_dat[7:0];
      end
      if (wd_wr & i_wb_sel[1]) begin
        wdata_q[15:8] <= i_wb_dat[15:8];
      end
    end
  end

  // ==========================================================
  // answer reception
  wire rsp_done = link.s_valid & ~link.s_first & (rx_idx_q == RX_IDX_LO);  // R1
  wire is_wr    = cmd_q[CTRL_WR_BIT];
  wire [7:0] expect_stat = is_wr ? (cmd_q & ~CTRL_WR_MASK) : cmd_q;
  wire match    = stat_q == expect_stat;
  // reads carry the data word too: the device has to ignore it
  wire [23:0] req_frame = {cmd_q, wdata_q};  // R6

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_idx_q <= 2'h0;
      stat_q   <= CTRL_IDLE;
      rhi_q    <= 8'h00;
    end else if (link.s_valid) begin
      if (link.s_first) begin
        stat_q   <= link.s_byte;
        rx_idx_q <= RX_IDX_HI;
      end else if (rx_idx_q == RX_IDX_HI) begin
        rhi_q    <= link.s_byte;
        rx_idx_q <= RX_IDX_LO;
      end else begin
        rx_idx_q <= 2'h0;
      end
    end
  end

  // ==========================================================
  // request sequence: a plain frame first, so a repeated request is fresh
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q  <= HS_IDLE;
      done_q   <= 1'b0;
      retry_q  <= 1'b0;
      rdata_q  <= 16'h0000;
      tx_sh_q  <= 24'h000000;
      tx_cnt_q <= 2'h0;
    end else begin
      if (tx_cnt_q != 2'h0) begin
        tx_sh_q  <= {tx_sh_q[15:0], 8'h00};
        tx_cnt_q <= tx_cnt_q - 2'h1;
      end
      unique case (state_q)
        HS_IDLE: begin
          if (start) begin
            done_q   <= 1'b0;
            retry_q  <= 1'b0;
            tx_sh_q  <= {CTRL_IDLE, 16'h0000};  // R18
            tx_cnt_q <= TX_CNT_FULL;
            state_q  <= HS_WAITC;
          end
        end
        HS_WAITC: begin
          if (rsp_done) begin
            tx_sh_q  <= req_frame;  // R1
            tx_cnt_q <= TX_CNT_FULL;
            state_q  <= HS_WAITR;
          end
        end
        HS_WAITR: begin
          if (rsp_done & match) begin
            done_q  <= 1'b1;
            state_q <= HS_IDLE;
            if (!is_wr) begin
              rdata_q <= {rhi_q, link.s_byte};  // R1
            end                                 // R10
          end else if (rsp_done) begin
            retry_q  <= 1'b1;
            tx_sh_q  <= req_frame;
            tx_cnt_q <= TX_CNT_FULL;
          end
        end
        default: begin
          state_q <= HS_IDLE;
        end
      endcase
    end
  end

  assign link.m_byte  = tx_sh_q[23:16];
  assign link.m_valid = tx_cnt_q != 2'h0;
  assign link.m_first = tx_cnt_q == TX_CNT_FULL;
  assign o_wb_ack     = ack_q;

endmodule : rac_host

// file: tb/rac_monitor.sv
// concurrent checks on the byte link between host end and device end
module rac_monitor
  import rac_pkg::*;
#(
  parameter logic [15:0] FW_VERSION = 16'h3030  // arbitrary value
) (
  input  wire logic       i_clk,    // system clock
  input  wire logic       i_rst,    // synchronous reset
  input  wire logic [7:0] m_byte,   // master byte
  input  wire logic       m_valid,  // master byte present
  input  wire logic       m_first,  // master byte 0
  input  wire logic [7:0] s_byte,   // device byte
  input  wire logic       s_valid,  // device byte present
  input  wire logic       s_first   // device byte 0
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // helper state
  logic [7:0] ctrl_q;     // control byte of the frame being answered
  logic       ans_first;  // status byte on the wire

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  assign ans_first = s_valid && s_first;

  always_ff @(posedge i_clk) begin
    if (i_rst) ctrl_q <= CTRL_IDLE;
    else if (m_valid && m_first) ctrl_q <= m_byte;
  end

  // ==========================================================
  // assertions
  a_first_valid: assert property (m_first |-> m_valid)
    else $error("first flag without valid byte");
  a_answer_delay: assert property (m_valid && m_first ##1 m_valid && !m_first ##1 m_valid && !m_first
    |-> ##2 ans_first) else $error("answer frame not two cycles after request");
  a_answer_three: assert property (ans_first |=> s_valid && !s_first ##1 s_valid && !s_first ##1 !s_valid)
    else $error("answer frame not three bytes");
  a_read_echo: assert property (ans_first && ctrl_q[7] && !ctrl_q[6] |-> s_byte == ctrl_q)
    else $error("read status differs from control byte");
  a_write_ack: assert property (ans_first && ctrl_q[7] && ctrl_q[6] |-> s_byte == (ctrl_q & ~CTRL_WR_MASK))
    else $error("write status not control with bit six cleared");
  a_plain_status: assert property (ans_first && !ctrl_q[7] |-> s_byte == CTRL_IDLE)
    else $error("plain frame answered as register access");
  a_fw_word: assert property (ans_first && ctrl_q == {2'b10, REG_FW_VERSION}
    |=> s_byte == FW_VERSION[15:8] ##1 s_byte == FW_VERSION[7:0]) else $error("version word wrong");
  a_no_talk_over: assert property (s_valid |-> !m_valid)
    else $error("master byte during answer");

  c_read: cover property (ans_first && ctrl_q[7] && !ctrl_q[6]);
  c_write: cover property (ans_first && ctrl_q[6]);
  c_plain: cover property (ans_first && !ctrl_q[7]);
endmodule : rac_monitor

// file: tb/tb.sv
// self-checking bench: wishbone host end driving the device end over the link
module tb
  import rac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] FW = 16'h5A17;  // arbitrary value
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] dat_w = 32'h00000000;
  logic [31:0] dat_r;
  logic        ack;
  logic [15:0] feat;
  logic        unl;
  logic        acc;
  logic [23:0] ans = 24'h000000;  // last three device bytes
  int          acc_cnt = 0;
  int          mismatches = 0;
  int          checks_done = 0;

  rac_link_if i_rac_link_if ();
  rac_device #(.FW_VERSION(FW)) i_rac_device (.i_clk(i_clk), .i_rst(i_rst), .link(i_rac_link_if),
    .o_feature_active(feat), .o_unlocked(unl), .o_access(acc));
  rac_host i_rac_host (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(dat_w), .o_wb_dat(dat_r), .o_wb_ack(ack), .link(i_rac_link_if));
  rac_monitor #(.FW_VERSION(FW)) i_rac_monitor (.i_clk(i_clk), .i_rst(i_rst),
    .m_byte(i_rac_link_if.m_byte), .m_valid(i_rac_link_if.m_valid), .m_first(i_rac_link_if.m_first),
    .s_byte(i_rac_link_if.s_byte), .s_valid(i_rac_link_if.s_valid), .s_first(i_rac_link_if.s_first));

  initial begin
    forever #4 i_clk = ~i_clk;
  end

  // wire-level capture, so byte order is judged independently of the host
  always @(posedge i_clk) begin
    if (i_rac_link_if.s_valid === 1'b1) ans <= {ans[15:0], i_rac_link_if.s_byte};
    if (acc === 1'b1) acc_cnt <= acc_cnt + 1;
  end

  // ==========================================================
  // report
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    check_word({15'h0000, got}, {15'h0000, exp});
  endtask : check_bit

  // ==========================================================
  // bus access
  task automatic wb_cycle(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (ack === 1'b1) break;
    end
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 50) begin
      mismatches++;
      give_verdict();
    end
  endtask : wb_cycle

  // one register access; data of a write answer is stale and not judged
  task automatic do_acc(input logic w, input logic [5:0] r, input logic [15:0] d, input logic [15:0] exp);
    logic [31:0] s;
    int n;
    wb_cycle(1'b1, HOST_WDATA, {16'h0000, d}, s);
    wb_cycle(1'b1, HOST_CMD, {24'h000000, 1'b0, w, r}, s);
    for (n = 0; n < 200; n++) begin
      wb_cycle(1'b0, HOST_STATUS, 32'h00000000, s);
      if (s[STAT_DONE_BIT] === 1'b1 && s[STAT_BUSY_BIT] === 1'b0) break;
    end
    if (n == 200) begin
      mismatches++;
      give_verdict();
    end
    check_bit(s[STAT_RETRY_BIT], 1'b0);
    check_word({8'h00, ans[23:16]}, {8'h00, 2'b10, r});
    wb_cycle(1'b0, HOST_RDATA, 32'h00000000, s);
    if (w == 1'b0) begin
      check_word(s[15:0], exp);
      check_word(ans[15:0], exp);
    end
  endtask : do_acc

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] q;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    check_bit(unl, 1'b0);
    do_acc(1'b0, REG_FW_VERSION, 16'hFFFF, FW);
    do_acc(1'b1, REG_FEATURE, 16'h0002, 16'h0000);
    do_acc(1'b0, REG_FEATURE, 16'h0000, REG_RST);
    do_acc(1'b1, REG_CODE_WORD, UNLOCK_CODE, 16'h0000);
    check_bit(unl, 1'b1);
    do_acc(1'b0, REG_CODE_WORD, 16'hFFFF, UNLOCK_CODE);
    do_acc(1'b1, REG_FEATURE, 16'h0002, 16'h0000);
    do_acc(1'b1, 6'h3F, 16'hBEEF, 16'h0000);
    do_acc(1'b1, REG_FW_VERSION, 16'h0000, 16'h0000);
    do_acc(1'b0, REG_FW_VERSION, 16'h0000, FW);
    do_acc(1'b0, 6'h3F, 16'h5555, 16'hBEEF);
    repeat (2) do_acc(1'b0, REG_FEATURE, 16'hAAAA, 16'h0002);
    check_word(feat, 16'h0000);
    do_acc(1'b1, REG_CODE_WORD, 16'h0000, 16'h0000);
    check_bit(unl, 1'b0);
    do_acc(1'b1, REG_FEATURE, 16'h0007, 16'h0000);
    do_acc(1'b0, REG_FEATURE, 16'h0000, 16'h0002);
    wb_cycle(1'b0, 4'h2, 32'h00000000, q);
    check_word(q[15:0], 16'h0000);
    // restart in mid-run
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    check_bit(unl, 1'b0);
    repeat (2) @(posedge i_clk);
    check_word(feat, 16'h0002);
    do_acc(1'b0, REG_CODE_WORD, 16'h0000, CODE_WORD_RST);
    do_acc(1'b0, REG_FEATURE, 16'h0000, 16'h0002);
    check_word(acc_cnt[15:0], 16'h0011);
    give_verdict();
  end
endmodule : tb
